/* hw/ahs_defines.svh */
// constants for the axis homing, servo handshake and stop control block
// assumes configuration inputs stay steady while an axis is in motion
// Notes on behaviour
// R1: count-start setting 0 starts zero-pulse counting when near switch turns active.
// R2: count-start setting 1 starts zero-pulse counting when near switch turns inactive.
// R3: count-start setting 2 homes without looking at the near switch.
// R4: near polarity 0 means closed contact is near; 1 means open contact.
// R5: limit polarity 0 means closed contact is limit; 1 means open contact.
// R6: count zero pulses during homing and halt when count equals setting.
// R7: homing starts from terminal, homing instruction, peripheral command or request flag.
// R8: after pulses end, flag servo end error if completion not seen in time.
// R9: completion timeout setting 0 skips the servo end check.
// R10: check runs for explicit check instruction and auto-checking drive instructions.
// R11: ready check 0 outputs pulses only while drive ready is asserted.
// R12: ready check 1 outputs pulses whatever the drive ready level.
// R13: stop terminal or stop request flag counts as a stop instruction.
// R14: stop modes 0 and 4 ignore stop in auto; manual stop clears errors.
// R15: stop mode 1 decelerates; next start drives the remaining distance.
// R16: modes 1 and 2 jump to end during interpolation or interrupt positioning.
// R17: mode 2 decelerates, drops remaining distance, next start resumes at next step.
// R18: modes 2, 3, 7 during dwell drop remaining time, go to next step.
// R19: modes 3 and 7 decelerate, drop remaining distance, jump to end step.
// R20: modes 3 and 7 in aux-code standby switch code to end, aux-on stays.
// R21: two-axis modes 5, 6 keep remain/next in interpolation unless continuous path.
// R22: single-axis linear instruction: modes 1, 5 remain; modes 2, 6 next.
// R23: near switch active during homing selects creep speed.
// R24: zero-signal count 0 stops at the selected transition without deceleration.
// R25: settings are taken from inputs held constant during positioning.
`ifndef AHS_DEFINES_SVH
`define AHS_DEFINES_SVH
`define AHS_CNT_RISE 2'h0
`define AHS_CNT_FALL 2'h1
`define AHS_CNT_NODOG 2'h2
`define AHS_SM_OFF 3'h0
`define AHS_SM_REM 3'h1
`define AHS_SM_NEXT 3'h2
`define AHS_SM_END 3'h3
`define AHS_SM_OFF_B 3'h4
`define AHS_SM_REM_IP 3'h5
`define AHS_SM_NEXT_IP 3'h6
`define AHS_SM_END_B 3'h7
`define AHS_CLK_NS 40
`define AHS_MS_NS 1000000
`define AHS_TMO_MAX_MS 5000
`endif

/* hw/ahs_pkg.sv */
// types shared by the axis control block
// assumes ahs_defines.svh supplies the numeric constants
package ahs_pkg;
	typedef enum logic [1:0] {
		HS_IDLE = 2'h0,
		HS_SEEK = 2'h1,
		HS_COUNT = 2'h2
	} ahs_home_t;
	typedef enum logic [0:0] {
		SV_IDLE = 1'h0,
		SV_WAIT = 1'h1
	} ahs_servo_t;
	typedef enum logic [1:0] {
		SA_IGNORE = 2'h0,
		SA_REMAIN = 2'h1,
		SA_NEXT = 2'h2,
		SA_END = 2'h3
	} ahs_stop_act_t;
endpackage : ahs_pkg

/* hw/ahs_axis_ctrl.sv */
// per-axis homing sequencer, servo handshakes and stop policy
// assumes all inputs synchronous to clk_in; contact inputs are 1 when closed
`timescale 1ns/1ps
`include "ahs_defines.svh"
module ahs_axis_ctrl #(
	parameter int MS_CYCLES = `AHS_MS_NS / `AHS_CLK_NS,
	parameter int ZCW = 16,
	parameter int TW = 13,
	parameter bit TWO_AXIS = 1'b1
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [1:0] cnt_start_sel_in,
	input wire logic near_pol_in,
	input wire logic limit_pol_in,
	input wire logic [ZCW-1:0] zero_count_in,
	input wire logic [TW-1:0] completion_timeout_setting_in,
	input wire logic ready_check_off_in,
	input wire logic [2:0] stop_mode_setting_in,
	input wire logic near_point_switch_in,
	input wire logic travel_limit_switch_in,
	input wire logic zero_point_pulse_input_in,
	input wire logic zero_return_terminal_in,
	input wire logic machine_homing_instr_in,
	input wire logic peripheral_homing_cmd_in,
	input wire logic homing_request_flag_in,
	input wire logic completion_check_instr_in,
	input wire logic auto_check_move_in,
	input wire logic pulse_done_in,
	input wire logic positioning_complete_input_in,
	input wire logic pulse_req_in,
	input wire logic drive_ready_input_in,
	input wire logic stop_terminal_in,
	input wire logic stop_request_flag_in,
	input wire logic manual_operation_mode_in,
	input wire logic interp_active_in,
	input wire logic interrupt_pos_active_in,
	input wire logic linear_interp_instr_in,
	input wire logic continuous_path_flag_in,
	input wire logic dwell_timer_instr_in,
	input wire logic aux_code_standby_in,
	input wire logic start_req_in,
	output logic home_busy_out,
	output logic creep_speed_out,
	output logic home_done_out,
	output logic home_abrupt_out,
	output logic near_point_out,
	output logic limit_reached_out,
	output logic pulse_enable_out,
	output logic servo_busy_out,
	output logic servo_end_error_out,
	output logic decel_stop_out,
	output logic discard_remaining_out,
	output logic jump_end_out,
	output logic dwell_skip_out,
	output logic aux_code_end_out,
	output logic error_clear_out,
	output logic resume_remaining_out,
	output logic resume_next_out
);
	localparam int PCW = $clog2(MS_CYCLES + 1);

	if (MS_CYCLES < 1 || TW < 13 || ZCW < 1) begin : g_bad_param
		$error("ahs_axis_ctrl: unsupported parameter values");
	end

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic ahs_pkg::ahs_stop_act_t stop_action(
		input logic [2:0] m,
		input logic ip,
		input logic it,
		input logic cp,
		input logic l31,
		input logic tw
	);
		ahs_pkg::ahs_stop_act_t a;
		logic ipm;
		a = ahs_pkg::SA_IGNORE;
		ipm = (m == `AHS_SM_REM_IP) || (m == `AHS_SM_NEXT_IP);
		if (m == `AHS_SM_REM || m == `AHS_SM_REM_IP) begin
			a = ahs_pkg::SA_REMAIN; // R15
		end else if (m == `AHS_SM_NEXT || m == `AHS_SM_NEXT_IP) begin
			a = ahs_pkg::SA_NEXT; // R17
		end else if (m == `AHS_SM_END || m == `AHS_SM_END_B) begin
			a = ahs_pkg::SA_END; // R19
		end
		if (a == ahs_pkg::SA_REMAIN || a == ahs_pkg::SA_NEXT) begin
			if (it) begin
				a = ahs_pkg::SA_END; // R16
			end else if (ip) begin
				if (tw) begin
					if (!ipm || cp) begin
						a = ahs_pkg::SA_END; // R21
					end
				end else if (!l31) begin
					a = ahs_pkg::SA_END; // R22
				end
			end
		end
		return a;
	endfunction : stop_action

	// ----------------------------------------------------------------
	// zero return sequencing
	// ----------------------------------------------------------------
	ahs_pkg::ahs_home_t hs_ff, nxt_hs;
	logic [ZCW-1:0] cnt_ff, nxt_cnt;
	logic near_prev_ff, nxt_near_prev;
	logic zp_prev_ff, nxt_zp_prev;
	logic src_prev_ff, nxt_src_prev;
	logic nxt_busy, nxt_creep, nxt_done, nxt_abrupt, nxt_limit;
	logic near_act, near_rise, near_fall, zp_edge, home_src, home_start;
	logic trig;

	always_comb begin
		near_act = near_point_switch_in ^ near_pol_in; // R4
		near_rise = near_act && !near_prev_ff;
		near_fall = !near_act && near_prev_ff;
		zp_edge = zero_point_pulse_input_in && !zp_prev_ff;
		home_src = zero_return_terminal_in || machine_homing_instr_in ||
			peripheral_homing_cmd_in || homing_request_flag_in; // R7
		home_start = home_src && !src_prev_ff;
		trig = ((cnt_start_sel_in == `AHS_CNT_RISE) && near_rise) || // R1 R25
			((cnt_start_sel_in == `AHS_CNT_FALL) && near_fall); // R2
		nxt_near_prev = near_act;
		nxt_zp_prev = zero_point_pulse_input_in;
		nxt_src_prev = home_src;
		nxt_limit = travel_limit_switch_in ^ limit_pol_in; // R5
		nxt_hs = hs_ff;
		nxt_cnt = cnt_ff;
		nxt_busy = home_busy_out;
		nxt_creep = creep_speed_out;
		nxt_done = 1'b0;
		nxt_abrupt = 1'b0;
		case (hs_ff)
			ahs_pkg::HS_IDLE: begin
				if (home_start) begin
					nxt_busy = 1'b1;
					nxt_cnt = '0;
					if (cnt_start_sel_in == `AHS_CNT_NODOG) begin
						nxt_hs = ahs_pkg::HS_COUNT; // R3
					end else begin
						nxt_hs = ahs_pkg::HS_SEEK;
					end
				end
			end
			ahs_pkg::HS_SEEK: begin
				if (near_act) begin
					nxt_creep = 1'b1; // R23
				end
				if (trig) begin
					nxt_hs = ahs_pkg::HS_COUNT;
				end
			end
			ahs_pkg::HS_COUNT: begin
				if (zero_count_in == '0) begin
					nxt_abrupt = 1'b1; // R24
					nxt_done = 1'b1;
					nxt_hs = ahs_pkg::HS_IDLE;
				end else if (zp_edge) begin
					nxt_cnt = ZCW'(cnt_ff + 1'b1);
					if (nxt_cnt == zero_count_in) begin
						nxt_done = 1'b1; // R6
						nxt_hs = ahs_pkg::HS_IDLE;
					end
				end
			end
			default: begin
				nxt_hs = ahs_pkg::HS_IDLE;
			end
		endcase
		if (nxt_done) begin
			nxt_busy = 1'b0;
			nxt_creep = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hs_ff <= ahs_pkg::HS_IDLE;
			cnt_ff <= '0;
			near_prev_ff <= 1'b0;
			zp_prev_ff <= 1'b0;
			src_prev_ff <= 1'b0;
			home_busy_out <= 1'b0;
			creep_speed_out <= 1'b0;
			home_done_out <= 1'b0;
			home_abrupt_out <= 1'b0;
			near_point_out <= 1'b0;
			limit_reached_out <= 1'b0;
		end else begin
			hs_ff <= nxt_hs;
			cnt_ff <= nxt_cnt;
			near_prev_ff <= nxt_near_prev;
			zp_prev_ff <= nxt_zp_prev;
			src_prev_ff <= nxt_src_prev;
			home_busy_out <= nxt_busy;
			creep_speed_out <= nxt_creep;
			home_done_out <= nxt_done;
			home_abrupt_out <= nxt_abrupt;
			near_point_out <= nxt_near_prev;
			limit_reached_out <= nxt_limit;
		end
	end

	// ----------------------------------------------------------------
	// servo end check and ready gating
	// ----------------------------------------------------------------
	ahs_pkg::ahs_servo_t sv_ff, nxt_sv;
	logic [PCW-1:0] pre_ff, nxt_pre;
	logic [TW-1:0] ms_ff, nxt_ms;
	logic nxt_err, nxt_pen, chk_start, err_set, nxt_clr;
	logic stop_evt;
	ahs_pkg::ahs_stop_act_t act;

	always_comb begin
		chk_start = completion_check_instr_in ||
			(auto_check_move_in && pulse_done_in); // R10
		nxt_sv = sv_ff;
		nxt_pre = pre_ff;
		nxt_ms = ms_ff;
		err_set = 1'b0;
		case (sv_ff)
			ahs_pkg::SV_IDLE: begin
				if (chk_start && completion_timeout_setting_in != '0) begin
					nxt_sv = ahs_pkg::SV_WAIT; // R9
					nxt_pre = '0;
					nxt_ms = '0;
				end
			end
			ahs_pkg::SV_WAIT: begin
				if (positioning_complete_input_in) begin
					nxt_sv = ahs_pkg::SV_IDLE;
				end else if (pre_ff == PCW'(MS_CYCLES - 1)) begin
					nxt_pre = '0;
					nxt_ms = TW'(ms_ff + 1'b1);
					if (nxt_ms >= completion_timeout_setting_in) begin
						err_set = 1'b1; // R8
						nxt_sv = ahs_pkg::SV_IDLE;
					end
				end else begin
					nxt_pre = PCW'(pre_ff + 1'b1);
				end
			end
			default: begin
				nxt_sv = ahs_pkg::SV_IDLE;
			end
		endcase
		nxt_err = servo_end_error_out;
		if (err_set) begin
			nxt_err = 1'b1;
		end else if (nxt_clr) begin
			nxt_err = 1'b0;
		end
		nxt_pen = pulse_req_in &&
			(ready_check_off_in || drive_ready_input_in); // R11 R12
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sv_ff <= ahs_pkg::SV_IDLE;
			pre_ff <= '0;
			ms_ff <= '0;
			servo_end_error_out <= 1'b0;
			servo_busy_out <= 1'b0;
			pulse_enable_out <= 1'b0;
		end else begin
			sv_ff <= nxt_sv;
			pre_ff <= nxt_pre;
			ms_ff <= nxt_ms;
			servo_end_error_out <= nxt_err;
			servo_busy_out <= (nxt_sv == ahs_pkg::SV_WAIT);
			pulse_enable_out <= nxt_pen;
		end
	end

	// ----------------------------------------------------------------
	// stop policy
	// ----------------------------------------------------------------
	logic stop_prev_ff, nxt_stop_prev, stop_src;
	ahs_pkg::ahs_stop_act_t pend_ff, nxt_pend;
	logic nxt_decel, nxt_disc, nxt_jend, nxt_dwell, nxt_aux;
	logic nxt_rrem, nxt_rnext, m37;

	always_comb begin
		stop_src = stop_terminal_in || stop_request_flag_in; // R13
		stop_evt = stop_src && !stop_prev_ff;
		nxt_stop_prev = stop_src;
		act = stop_action(stop_mode_setting_in, interp_active_in,
			interrupt_pos_active_in, continuous_path_flag_in,
			linear_interp_instr_in, TWO_AXIS); // R25
		m37 = (stop_mode_setting_in == `AHS_SM_END) ||
			(stop_mode_setting_in == `AHS_SM_END_B);
		nxt_decel = 1'b0;
		nxt_disc = 1'b0;
		nxt_jend = 1'b0;
		nxt_dwell = 1'b0;
		nxt_aux = 1'b0;
		nxt_clr = 1'b0;
		nxt_rrem = 1'b0;
		nxt_rnext = 1'b0;
		nxt_pend = pend_ff;
		if (stop_evt && act == ahs_pkg::SA_IGNORE) begin
			nxt_clr = manual_operation_mode_in; // R14
		end else if (stop_evt) begin
			nxt_decel = 1'b1;
			nxt_disc = (act != ahs_pkg::SA_REMAIN); // R17 R19
			nxt_jend = (act == ahs_pkg::SA_END); // R16 R19
			nxt_pend = act; // R15
			nxt_dwell = dwell_timer_instr_in &&
				(act == ahs_pkg::SA_NEXT || m37); // R18
			nxt_aux = aux_code_standby_in && m37; // R20
		end else if (start_req_in) begin
			nxt_rrem = (pend_ff == ahs_pkg::SA_REMAIN); // R15
			nxt_rnext = (pend_ff == ahs_pkg::SA_NEXT); // R17
			nxt_pend = ahs_pkg::SA_IGNORE;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stop_prev_ff <= 1'b0;
			pend_ff <= ahs_pkg::SA_IGNORE;
			decel_stop_out <= 1'b0;
			discard_remaining_out <= 1'b0;
			jump_end_out <= 1'b0;
			dwell_skip_out <= 1'b0;
			aux_code_end_out <= 1'b0;
			error_clear_out <= 1'b0;
			resume_remaining_out <= 1'b0;
			resume_next_out <= 1'b0;
		end else begin
			stop_prev_ff <= nxt_stop_prev;
			pend_ff <= nxt_pend;
			decel_stop_out <= nxt_decel;
			discard_remaining_out <= nxt_disc;
			jump_end_out <= nxt_jend;
			dwell_skip_out <= nxt_dwell;
			aux_code_end_out <= nxt_aux;
			error_clear_out <= nxt_clr;
			resume_remaining_out <= nxt_rrem;
			resume_next_out <= nxt_rnext;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	a_rise_count_start: assert property ( // R1
		hs_ff == ahs_pkg::HS_SEEK && near_rise &&
		cnt_start_sel_in == `AHS_CNT_RISE |=> hs_ff == ahs_pkg::HS_COUNT)
		else $error("rise count start missed");
	a_fall_count_start: assert property ( // R2
		hs_ff == ahs_pkg::HS_SEEK && near_fall &&
		cnt_start_sel_in == `AHS_CNT_FALL |=> hs_ff == ahs_pkg::HS_COUNT)
		else $error("fall count start missed");
	a_nodog_start: assert property ( // R3
		hs_ff == ahs_pkg::HS_IDLE && home_start &&
		cnt_start_sel_in == `AHS_CNT_NODOG |=> hs_ff == ahs_pkg::HS_COUNT)
		else $error("no-dog homing did not count");
	a_limit_polarity: assert property ( // R5
		1'b1 |=> limit_reached_out ==
		($past(travel_limit_switch_in) ^ $past(limit_pol_in)))
		else $error("limit polarity wrong");
	a_count_halt: assert property ( // R6
		hs_ff == ahs_pkg::HS_COUNT && zp_edge && zero_count_in != '0 &&
		ZCW'(cnt_ff + 1'b1) == zero_count_in
		|=> home_done_out && !home_busy_out)
		else $error("homing did not halt at count");
	a_skip_check: assert property ( // R9
		sv_ff == ahs_pkg::SV_IDLE && completion_timeout_setting_in == '0
		|=> !servo_busy_out)
		else $error("check ran with zero timeout");
	a_ready_gate: assert property ( // R11
		!ready_check_off_in && !drive_ready_input_in |=> !pulse_enable_out)
		else $error("pulse without ready");
	a_ready_bypass: assert property ( // R12
		ready_check_off_in && pulse_req_in |=> pulse_enable_out)
		else $error("pulse blocked with check off");
	a_stop_ignored: assert property ( // R14
		stop_evt && act == ahs_pkg::SA_IGNORE
		|=> !decel_stop_out && error_clear_out == $past(manual_operation_mode_in))
		else $error("ignored stop acted");
	a_creep_speed: assert property ( // R23
		hs_ff == ahs_pkg::HS_SEEK && near_act |=> creep_speed_out)
		else $error("creep not selected");
endmodule : ahs_axis_ctrl

/* verification/ahs_drive_model.sv */
// drive model: zero pulses while the axis moves, completion after a move
// assumes bench clock and active-low reset; slow_in withholds completion
`timescale 1ns/1ps
module ahs_drive_model (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic moving_in,
	input wire logic move_end_in,
	input wire logic slow_in,
	output logic zero_pulse_out,
	output logic complete_out
);
	logic [1:0] ph_ff;
	logic [2:0] dly_ff;
	// one zero pulse per four cycles of motion
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ph_ff <= 2'h0;
			dly_ff <= 3'h0;
			complete_out <= 1'b0;
		end else begin
			ph_ff <= moving_in ? ph_ff + 2'h1 : 2'h0;
			if (move_end_in) begin
				complete_out <= 1'b0;
				dly_ff <= slow_in ? 3'h0 : 3'h3;
			end else if (dly_ff != 3'h0) begin
				dly_ff <= dly_ff - 3'h1;
				complete_out <= (dly_ff == 3'h1);
			end
		end
	end
	assign zero_pulse_out = moving_in & ph_ff[1];
endmodule : ahs_drive_model

/* verification/ahs_axis_ctrl_bench.sv */
// bench for the axis control block: homing, servo handshake, stop policy
// assumes the drive model stands on the far side of the axis
`timescale 1ns/1ps
module ahs_axis_ctrl_bench;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [1:0] sel = 2'h0;
	logic npol = 1'b0, lpol = 1'b0, rdy_off = 1'b0, slow = 1'b0;
	logic [15:0] zc = 16'h0000;
	logic [12:0] tmo = 13'h0000;
	logic [2:0] mode = 3'h0;
	logic nsw = 1'b0, lsw = 1'b0, zp, cpl, zq1_ff, zq2_ff;
	logic [3:0] src = 4'h0;
	logic chk = 1'b0, auto = 1'b0, pdone = 1'b0, preq = 1'b0, rdy = 1'b0;
	logic stp_t = 1'b0, stp_f = 1'b0, man = 1'b0, ip = 1'b0, ir = 1'b0;
	logic cp = 1'b0, dw = 1'b0, aux = 1'b0, start = 1'b0;
	logic busy, creep, done, abrupt, near, lim, pen, sbusy, serr;
	logic decel, disc, jend, dskip, auxe, eclr, rrem, rnext;
	int n_errors = 0, n_tests = 0, seed = 32'hA837, cyc = 0, cnt, i, k;

	ahs_axis_ctrl #(.MS_CYCLES(4)) u_ahs_axis_ctrl (
		.clk_in(clk_in), .rstn_in(rstn_in), .cnt_start_sel_in(sel),
		.near_pol_in(npol), .limit_pol_in(lpol), .zero_count_in(zc),
		.completion_timeout_setting_in(tmo), .ready_check_off_in(rdy_off),
		.stop_mode_setting_in(mode), .near_point_switch_in(nsw),
		.travel_limit_switch_in(lsw), .zero_point_pulse_input_in(zp),
		.zero_return_terminal_in(src[0]), .machine_homing_instr_in(src[1]),
		.peripheral_homing_cmd_in(src[2]), .homing_request_flag_in(src[3]),
		.completion_check_instr_in(chk), .auto_check_move_in(auto),
		.pulse_done_in(pdone), .positioning_complete_input_in(cpl),
		.pulse_req_in(preq), .drive_ready_input_in(rdy),
		.stop_terminal_in(stp_t), .stop_request_flag_in(stp_f),
		.manual_operation_mode_in(man), .interp_active_in(ip),
		.interrupt_pos_active_in(ir), .linear_interp_instr_in(1'b0),
		.continuous_path_flag_in(cp), .dwell_timer_instr_in(dw),
		.aux_code_standby_in(aux), .start_req_in(start),
		.home_busy_out(busy), .creep_speed_out(creep), .home_done_out(done),
		.home_abrupt_out(abrupt), .near_point_out(near),
		.limit_reached_out(lim), .pulse_enable_out(pen),
		.servo_busy_out(sbusy), .servo_end_error_out(serr),
		.decel_stop_out(decel), .discard_remaining_out(disc),
		.jump_end_out(jend), .dwell_skip_out(dskip),
		.aux_code_end_out(auxe), .error_clear_out(eclr),
		.resume_remaining_out(rrem), .resume_next_out(rnext)
	);
	ahs_drive_model u_ahs_drive_model (
		.clk_in(clk_in), .rstn_in(rstn_in), .moving_in(busy),
		.move_end_in(pdone), .slow_in(slow), .zero_pulse_out(zp),
		.complete_out(cpl)
	);

	always #20 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		zq2_ff <= zq1_ff;
		zq1_ff <= zp;
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	task automatic check(input logic got, input logic exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : check

	task automatic cyc_n(input int n);
		repeat (n) @(negedge clk_in);
	endtask : cyc_n

	// -------------------------------------------------------------
	// homing and stop expectations
	// -------------------------------------------------------------
	task automatic home(input int s, input logic [1:0] cs, input logic pl,
		input logic [15:0] kz);
		logic cr;
		sel = cs;
		npol = pl;
		zc = kz;
		nsw = pl;
		cr = 1'b0;
		cnt = 0;
		@(negedge clk_in);
		src[s] = 1'b1;
		@(negedge clk_in);
		check(busy, 1'b1, "homing start");
		if (cs != 2'h2) begin
			@(negedge zp);
			@(negedge clk_in);
			nsw = ~pl;
			if (cs == 2'h1) begin
				cyc_n(3);
				cr = creep;
				@(negedge zp);
				@(negedge clk_in);
				nsw = pl;
			end
		end
		repeat (200) begin
			@(negedge clk_in);
			cr |= creep;
			if (zq1_ff & ~zq2_ff) cnt++;
			if (done) break;
		end
		check(done, 1'b1, "homing done");
		check(cnt == kz, 1'b1, "zero pulse count");
		check(abrupt, kz == 16'h0000, "abrupt stop");
		check(cr, cs != 2'h2, "creep speed");
		@(negedge clk_in);
		check(busy, 1'b0, "homing idle");
		src[s] = 1'b0;
	endtask : home

	function automatic logic [1:0] exp_act(input logic [2:0] m);
		logic [1:0] a;
		a = m[1:0];
		if (a != 2'h0 && (ir || (ip && !(m[2] && !cp)))) a = 2'h3;
		return a;
	endfunction : exp_act

	task automatic stop_one();
		logic [1:0] a;
		a = exp_act(mode);
		if (k[0]) stp_t = 1'b1;
		else stp_f = 1'b1;
		@(negedge clk_in);
		check(decel, a != 2'h0, "decelerate");
		check(disc, a[1], "discard distance");
		check(jend, a == 2'h3, "jump end");
		check(dskip, dw & (a == 2'h2 | mode[1:0] == 2'h3), "dwell");
		check(auxe, aux & (mode[1:0] == 2'h3), "aux end code");
		check(eclr, man & (a == 2'h0), "error clear");
		stp_t = 1'b0;
		stp_f = 1'b0;
		start = 1'b1;
		@(negedge clk_in);
		start = 1'b0;
		check(rrem, a == 2'h1, "resume remaining");
		check(rnext, a == 2'h2, "resume next");
	endtask : stop_one

	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		cyc_n(4);
		check(busy | serr | pen | decel, 1'b0, "reset outputs");
		rstn_in = 1'b1;
		for (i = 0; i < 100; i++) begin
			{nsw, lsw, npol, lpol, preq, rdy, rdy_off} = 7'($random(seed));
			@(negedge clk_in);
			check(near, nsw ^ npol, "near polarity");
			check(lim, lsw ^ lpol, "limit polarity");
			check(pen, preq & (rdy_off | rdy), "pulse gate");
		end
		for (i = 0; i < 6; i++) home(i % 4, 2'(i % 3), i[0], 16'(i));
		tmo = 13'h0002;
		auto = 1'b1;
		pdone = 1'b1;
		@(negedge clk_in);
		pdone = 1'b0;
		check(sbusy, 1'b1, "auto check start");
		cyc_n(6);
		check(sbusy | serr, 1'b0, "completion in time");
		slow = 1'b1;
		auto = 1'b0;
		pdone = 1'b1;
		chk = 1'b1;
		@(negedge clk_in);
		pdone = 1'b0;
		chk = 1'b0;
		check(sbusy, 1'b1, "check instr start");
		cyc_n(5);
		check(serr, 1'b0, "error too early");
		cyc_n(4);
		check(serr, 1'b1, "servo end error");
		tmo = 13'h0000;
		chk = 1'b1;
		@(negedge clk_in);
		chk = 1'b0;
		check(sbusy, 1'b0, "check disabled");
		man = 1'b1;
		k = 0;
		stop_one();
		check(serr, 1'b0, "error cleared");
		for (k = 1; k < 64; k++) begin
			{mode, ip, ir, cp, dw, aux, man} = 9'($random(seed));
			if (k < 8) mode = 3'(k);
			stop_one();
		end
		print_verdict();
	end
endmodule : ahs_axis_ctrl_bench
